//--- design/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// register offsets on the plain register port
`define ACS_OFF_RES_LOW 3'h0
`define ACS_OFF_RES_HIGH 3'h1
`define ACS_OFF_CTRL 3'h2
`define ACS_OFF_INSEL 3'h3
`define ACS_OFF_TRIG 3'h4

// converter_control_register fields
`define ACS_CTRL_EN_BIT 7
`define ACS_CTRL_START_BIT 6
`define ACS_CTRL_AUTO_BIT 5
`define ACS_CTRL_DONE_BIT 4
`define ACS_CTRL_IE_BIT 3
`define ACS_CTRL_DIV_LSB 0

// input_select_register fields
`define ACS_INSEL_REF_LSB 6
`define ACS_INSEL_LEFT_BIT 5
`define ACS_INSEL_CHAN_LSB 0
`define ACS_CHAN_DIFF_FIRST 5'h08

// trigger_control_register fields
`define ACS_TRIG_SRC_LSB 5
`define ACS_TRIG_FREE 3'h0

// reset values
`define ACS_RST_BYTE 8'h00
`define ACS_RST_RESULT 10'h000

// timing in half converter clock cycles, trigger sync in i_mclk cycles
`define ACS_HALF_NORMAL 6'h1A
`define ACS_HALF_FIRST 6'h32
`define ACS_HALF_AUTO 6'h1B
`define ACS_HALF_DIFF 6'h1C
`define ACS_SH_NORMAL 6'h03
`define ACS_SH_FIRST 6'h1B
`define ACS_SH_AUTO 6'h04
`define ACS_SH_DIFF 6'h05
`define ACS_TRIG_SYNC_CYCLES 3

// prescaler: ratio is two to the power of the select, never below two
`define ACS_DIV_MIN_SHIFT 3'h1

`endif

//--- design/acs_pkg.sv
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_WAIT = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_s;

    typedef struct packed {
        logic [1:0] reference;
        logic [4:0] channel;
    } acs_select_s;

endpackage

//--- design/acs_prescaler.sv
`include "acs_map.svh"

module acs_prescaler #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // control
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic [2:0] i_div_sel,
    // converter clock enables
    output logic o_rise_tick,
    output logic o_fall_tick,
    output logic o_half_phase
);
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] shift;
    logic [CNT_W:0] ratio;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] mid;

    always_comb
    begin
        shift = (i_div_sel < `ACS_DIV_MIN_SHIFT) ? `ACS_DIV_MIN_SHIFT
                                                 : i_div_sel;
        ratio = (CNT_W+1)'(1) << shift;
        limit = CNT_W'(ratio - (CNT_W+1)'(1));
        mid = CNT_W'((ratio >> 1) - (CNT_W+1)'(1));
    end

    assign o_rise_tick = i_run && !i_restart && (cnt_reg == limit);
    assign o_fall_tick = i_run && !i_restart && (cnt_reg == mid);

    // held in reset while the converter is off
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !i_run || i_restart)
            cnt_reg <= '0;
        // a smaller ratio written mid-count must not wait for a full wrap
        else if (cnt_reg >= limit)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + CNT_W'(1);
    end

    // half-rate converter clock
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !i_run || i_restart)
            o_half_phase <= 1'b0;
        else if (o_rise_tick)
            o_half_phase <= !o_half_phase;
    end

endmodule // acs_prescaler

//--- design/acs_sequencer.sv
`include "acs_map.svh"

module acs_sequencer (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // register port
    input wire acs_pkg::acs_bus_req_s i_bus,
    output logic [7:0] o_rdata,
    // trigger sources, index 0 unused (done flag)
    input wire logic [7:0] i_trigger_sources,
    // analog converter side
    input wire logic [9:0] i_sar_result,
    output logic o_analog_enable,
    output logic o_sample_hold,
    output acs_pkg::acs_select_s o_select,
    output logic o_conv_done_irq
);
    import acs_pkg::*;

    acs_state_e state_reg;
    logic enable_reg;
    logic start_bit_reg;
    logic auto_reg;
    logic done_flag_reg;
    logic irq_en_reg;
    logic [2:0] div_sel_reg;
    logic left_align_reg;
    acs_select_s sel_reg;
    acs_select_s act_sel_reg;
    logic [2:0] trig_src_reg;
    logic [9:0] data_reg;
    logic lock_reg;
    logic first_reg;
    logic [5:0] half_reg;
    logic [5:0] total_reg;
    logic [5:0] sh_point_reg;
    logic trig_prev_reg;
    logic [`ACS_TRIG_SYNC_CYCLES-1:0] trig_pipe_reg;
    logic [9:0] res_meta_reg;
    logic [9:0] res_sync_reg;
    logic sample_reg;
    logic [7:0] rdata_reg;

    logic rise_tick;
    logic fall_tick;
    logic half_phase;
    logic tick;
    logic wr_ctrl;
    logic sw_start;
    logic free_run;
    logic diff_chan;
    logic trig_level;
    logic trig_edge;
    logic fire;
    logic complete;
    logic last_cycle;
    logic track;
    logic rd_low;
    logic rd_high;
    logic [5:0] nx_total;
    logic [5:0] nx_sh;
    logic [7:0] res_low;
    logic [7:0] res_high;

    acs_prescaler #(
        .CNT_W(7)
    ) u_prescaler (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_run(enable_reg),
        .i_restart(fire),
        .i_div_sel(div_sel_reg),
        .o_rise_tick(rise_tick),
        .o_fall_tick(fall_tick),
        .o_half_phase(half_phase)
    );

    assign tick = rise_tick || fall_tick;
    assign wr_ctrl = i_bus.wr && (i_bus.addr == `ACS_OFF_CTRL);
    assign sw_start = wr_ctrl && i_bus.wdata[`ACS_CTRL_START_BIT]
                      && enable_reg && (state_reg == ACS_IDLE);
    assign free_run = auto_reg && (trig_src_reg == `ACS_TRIG_FREE);
    assign diff_chan = act_sel_reg.channel >= `ACS_CHAN_DIFF_FIRST;
    assign trig_level = i_trigger_sources[trig_src_reg];
    // edges only count while idle and nothing is pending
    assign trig_edge = enable_reg && auto_reg && !free_run && trig_level
                       && !trig_prev_reg && (state_reg == ACS_IDLE)
                       && (trig_pipe_reg == '0);
    assign fire = trig_pipe_reg[`ACS_TRIG_SYNC_CYCLES-1];
    assign complete = (state_reg == ACS_CONV) && tick
                      && (half_reg == 6'(total_reg - 6'h01));
    assign last_cycle = (state_reg == ACS_CONV)
                        && (half_reg >= 6'(total_reg - 6'h02));
    assign track = (state_reg != ACS_CONV) || last_cycle;
    assign rd_low = i_bus.rd && (i_bus.addr == `ACS_OFF_RES_LOW);
    assign rd_high = i_bus.rd && (i_bus.addr == `ACS_OFF_RES_HIGH);

    // length and sample point of the conversion about to start
    always_comb
    begin
        if (first_reg || (fire && diff_chan))
        begin
            nx_total = `ACS_HALF_FIRST;
            nx_sh = `ACS_SH_FIRST;
        end
        else if (fire)
        begin
            nx_total = `ACS_HALF_AUTO;
            nx_sh = `ACS_SH_AUTO;
        end
        else if (diff_chan && ((state_reg == ACS_CONV) || half_phase))
        begin
            nx_total = `ACS_HALF_DIFF;
            nx_sh = `ACS_SH_DIFF;
        end
        else
        begin
            nx_total = `ACS_HALF_NORMAL;
            nx_sh = `ACS_SH_NORMAL;
        end
    end

    // conversion sequence
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !enable_reg)
        begin
            state_reg <= ACS_IDLE;
            half_reg <= 6'h00;
            total_reg <= `ACS_HALF_NORMAL;
            sh_point_reg <= `ACS_SH_NORMAL;
        end
        else
        begin
            case (state_reg)
                ACS_IDLE:
                begin
                    if (fire)
                    begin
                        state_reg <= ACS_CONV;
                        half_reg <= 6'h00;
                        total_reg <= nx_total;
                        sh_point_reg <= nx_sh;
                    end
                    else if (sw_start)
                        state_reg <= ACS_WAIT;
                end
                ACS_WAIT:
                begin
                    if (rise_tick)
                    begin
                        state_reg <= ACS_CONV;
                        half_reg <= 6'h00;
                        total_reg <= nx_total;
                        sh_point_reg <= nx_sh;
                    end
                end
                ACS_CONV:
                begin
                    if (complete && free_run)
                    begin
                        half_reg <= 6'h00;
                        total_reg <= nx_total;
                        sh_point_reg <= nx_sh;
                    end
                    else if (complete)
                        state_reg <= ACS_IDLE;
                    else if (tick)
                        half_reg <= half_reg + 6'h01;
                end
                default:
                    state_reg <= ACS_IDLE;
            endcase
        end
    end

    // start bit mirrors any conversion in progress
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !enable_reg)
            start_bit_reg <= 1'b0;
        else if (sw_start || (fire && state_reg == ACS_IDLE))
            start_bit_reg <= 1'b1;
        else if (complete && !free_run)
            start_bit_reg <= 1'b0;
    end

    // first conversion after enabling is extended
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !enable_reg)
            first_reg <= 1'b1;
        else if ((state_reg == ACS_WAIT && rise_tick) || fire)
            first_reg <= 1'b0;
    end

    // trigger edge detect and cpu-clock synchronisation delay
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            trig_prev_reg <= 1'b0;
            trig_pipe_reg <= '0;
        end
        else
        begin
            trig_prev_reg <= trig_level;
            trig_pipe_reg <= {trig_pipe_reg[`ACS_TRIG_SYNC_CYCLES-2:0],
                              trig_edge};
        end
    end

    // control register fields
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            enable_reg <= 1'b0;
            auto_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            div_sel_reg <= 3'h0;
        end
        else if (wr_ctrl)
        begin
            enable_reg <= i_bus.wdata[`ACS_CTRL_EN_BIT];
            auto_reg <= i_bus.wdata[`ACS_CTRL_AUTO_BIT];
            irq_en_reg <= i_bus.wdata[`ACS_CTRL_IE_BIT];
            div_sel_reg <= i_bus.wdata[`ACS_CTRL_DIV_LSB +: 3];
        end
    end

    // done flag: completion wins over a write-one clear
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            done_flag_reg <= 1'b0;
        else if (complete)
            done_flag_reg <= 1'b1;
        else if (wr_ctrl && i_bus.wdata[`ACS_CTRL_DONE_BIT])
            done_flag_reg <= 1'b0;
    end

    // selection and trigger registers
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            sel_reg <= '0;
            left_align_reg <= 1'b0;
            trig_src_reg <= 3'h0;
        end
        else if (i_bus.wr && i_bus.addr == `ACS_OFF_INSEL)
        begin
            sel_reg.reference <= i_bus.wdata[`ACS_INSEL_REF_LSB +: 2];
            sel_reg.channel <= i_bus.wdata[`ACS_INSEL_CHAN_LSB +: 5];
            left_align_reg <= i_bus.wdata[`ACS_INSEL_LEFT_BIT];
        end
        else if (i_bus.wr && i_bus.addr == `ACS_OFF_TRIG)
            trig_src_reg <= i_bus.wdata[`ACS_TRIG_SRC_LSB +: 3];
    end

    // selection seen by the analog side
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            act_sel_reg <= '0;
        else if (enable_reg && track)
            act_sel_reg <= sel_reg;
    end

    // result pins come from the analog domain
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            res_meta_reg <= `ACS_RST_RESULT;
            res_sync_reg <= `ACS_RST_RESULT;
        end
        else
        begin
            res_meta_reg <= i_sar_result;
            res_sync_reg <= res_meta_reg;
        end
    end

    // result store, blocked while the byte pair is locked
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            data_reg <= `ACS_RST_RESULT;
        else if (complete && !lock_reg)
            data_reg <= res_sync_reg;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            lock_reg <= 1'b0;
        else if (rd_low)
            lock_reg <= 1'b1;
        else if (rd_high)
            lock_reg <= 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            sample_reg <= 1'b0;
        else
            sample_reg <= (state_reg == ACS_CONV) && tick
                          && (half_reg == 6'(sh_point_reg - 6'h01));
    end

    // byte alignment
    always_comb
    begin
        if (left_align_reg)
        begin
            res_high = data_reg[9:2];
            res_low = {data_reg[1:0], 6'h00};
        end
        else
        begin
            res_high = {6'h00, data_reg[9:8]};
            res_low = data_reg[7:0];
        end
    end

    // read data stand one cycle after the strobe
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            rdata_reg <= `ACS_RST_BYTE;
        else if (i_bus.rd)
        begin
            case (i_bus.addr)
                `ACS_OFF_RES_LOW: rdata_reg <= res_low;
                `ACS_OFF_RES_HIGH: rdata_reg <= res_high;
                `ACS_OFF_CTRL: rdata_reg <= {enable_reg, start_bit_reg,
                    auto_reg, done_flag_reg, irq_en_reg, div_sel_reg};
                `ACS_OFF_INSEL: rdata_reg <= {sel_reg.reference,
                    left_align_reg, sel_reg.channel};
                `ACS_OFF_TRIG: rdata_reg <= {trig_src_reg, 5'h00};
                default: rdata_reg <= `ACS_RST_BYTE;
            endcase
        end
        else
            rdata_reg <= `ACS_RST_BYTE;
    end

    assign o_rdata = rdata_reg;
    assign o_analog_enable = enable_reg;
    assign o_sample_hold = sample_reg;
    assign o_select = act_sel_reg;
    assign o_conv_done_irq = done_flag_reg && irq_en_reg;

    a_start_reads_busy: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (state_reg == ACS_CONV) |-> start_bit_reg)
        else $error("start bit low during a conversion");

    a_start_on_edge: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst)
        (state_reg == ACS_WAIT && !rise_tick && enable_reg)
        |=> state_reg != ACS_CONV)
        else $error("software conversion began off a converter edge");

    a_single_clears: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (complete && !free_run)
        |=> !start_bit_reg && state_reg == ACS_IDLE)
        else $error("start bit not cleared at completion");

    a_free_restart: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (complete && free_run && enable_reg)
        |=> state_reg == ACS_CONV && start_bit_reg && half_reg == 6'h00)
        else $error("free running did not restart");

    a_lock_holds_data: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (lock_reg && !rd_high) |=> $stable(data_reg))
        else $error("locked result changed");

    a_lost_sets_flag: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) complete |=> done_flag_reg)
        else $error("done flag missing after completion");

    a_prescaler_held: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) !enable_reg |-> !rise_tick && !fall_tick)
        else $error("prescaler ran while disabled");

    a_select_frozen: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (state_reg == ACS_CONV && !last_cycle)
        |=> $stable(act_sel_reg))
        else $error("selection changed mid conversion");

    a_trigger_delay: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) trig_edge |-> ##3 fire)
        else $error("trigger start not three cycles after edge");

    a_edge_dropped: assert property (@(posedge i_mclk)
        disable iff (i_sys_rst) (state_reg == ACS_CONV) |-> !trig_edge)
        else $error("trigger edge accepted during conversion");

endmodule // acs_sequencer

//--- tb/acs_analog_model.sv
module acs_analog_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // converter control from the sequencer
    input wire logic i_sample_hold,
    input wire logic i_analog_enable,
    input wire acs_pkg::acs_select_s i_select,
    // result towards the sequencer
    output logic [9:0] o_sar_result
);
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;

    logic [9:0] held_reg;

    // result encodes the selection seen at the sample point
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            held_reg <= 10'h000;
        else if (i_sample_hold)
            held_reg <= {3'h5, i_select};
    end

    // powered down: the held value is driven inverted on the line
    assign o_sar_result = i_analog_enable ? held_reg : ~held_reg;
endmodule // acs_analog_model

//--- tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;

    logic i_mclk;
    logic i_sys_rst;
    acs_bus_req_s bus;
    logic [7:0] rdata;
    logic [7:0] trig;
    logic [9:0] sar;
    logic aen;
    logic sh;
    logic irq;
    acs_select_s sel;
    logic irq_q = 1'b0;
    logic trig_q = 1'b0;
    logic [15:0] d;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int sh_cyc = 0;
    int sh_gap = 0;
    int sh_n = 0;
    int st_cyc = 0;
    int tr_cyc = 0;
    int done_cyc = 0;
    int n0;
    int r;

    acs_sequencer acs_sequencer_inst (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_bus(bus),
        .o_rdata(rdata),
        .i_trigger_sources(trig),
        .i_sar_result(sar),
        .o_analog_enable(aen),
        .o_sample_hold(sh),
        .o_select(sel),
        .o_conv_done_irq(irq)
    );

    acs_analog_model acs_analog_model_inst (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_sample_hold(sh),
        .i_analog_enable(aen),
        .i_select(sel),
        .o_sar_result(sar)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task end_of_test;
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic [15:0] in_rng(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
    endfunction

    // event timestamps, all taken at the edge the design samples
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        irq_q <= irq;
        trig_q <= trig[2];
        if (sh)
        begin
            sh_gap <= cyc - sh_cyc;
            sh_cyc <= cyc;
            sh_n <= sh_n + 1;
        end
        if (irq && !irq_q)
            done_cyc <= cyc;
        if (bus.wr && bus.addr == 3'h2 && bus.wdata[6])
            st_cyc <= cyc;
        if (trig[2] && !trig_q)
            tr_cyc <= cyc;
        if (cyc == 40000)
        begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end

    task wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        bus <= {a, v, 1'b1, 1'b0};
        @(posedge i_mclk);
        bus <= '0;
        #1;
    endtask

    task rd_reg(input logic [2:0] a, output logic [15:0] v);
        @(posedge i_mclk);
        bus <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge i_mclk);
        bus <= '0;
        #1;
        v = 16'(rdata);
    endtask

    task wait_done;
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 3000)
        begin
            @(posedge i_mclk);
            k++;
        end
        @(posedge i_mclk);
        #1;
    endtask

    task wait_samples(input int n);
        int k;
        int target;
        k = 0;
        target = sh_n + n;
        while (sh_n < target && k < 3000)
        begin
            @(posedge i_mclk);
            k++;
        end
        @(posedge i_mclk);
        #1;
    endtask

    // start, clear done, irq enable, given divider
    task conv(input logic [2:0] s);
        wr_reg(3'h2, 8'hD8 | {5'h00, s});
        wait_done;
    endtask

    initial
    begin
        i_sys_rst = 1'b1;
        bus = '0;
        trig = 8'h00;
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++)
        begin
            rd_reg(3'(a), d);
            chk(d, 16'h0000);
        end
        wr_reg(3'h3, 8'h43);
        chk(16'(sel), 16'h0000);
        wr_reg(3'h2, 8'hCB);
        rd_reg(3'h2, d);
        chk(d, 16'h008B);
        chk(16'(sel), 16'h0023);
        chk(16'(aen), 16'h0001);
        n0 = sh_n;
        wr_reg(3'h2, 8'hCB);
        rd_reg(3'h2, d);
        chk(d, 16'h00CB);
        wait_done;
        chk(in_rng(done_cyc - st_cyc, 200, 212), 16'h0001);
        chk(in_rng(sh_cyc - st_cyc, 108, 120), 16'h0001);
        chk(16'(sh_n - n0), 16'h0001);
        rd_reg(3'h2, d);
        chk(d, 16'h009B);
        rd_reg(3'h0, d);
        chk(d, 16'h00A3);
        rd_reg(3'h1, d);
        chk(d, 16'h0002);
        wr_reg(3'h3, 8'h63);
        rd_reg(3'h0, d);
        chk(d, 16'h00C0);
        rd_reg(3'h1, d);
        chk(d, 16'h00A8);
        wr_reg(3'h3, 8'h43);
        for (int s = 1; s < 5; s++)
        begin
            r = 1 << s;
            conv(3'(s));
            chk(in_rng(done_cyc - st_cyc, 13 * r, 14 * r + 4), 16'h0001);
            chk(in_rng(sh_cyc - st_cyc, 3 * r / 2, 5 * r / 2 + 3), 16'h0001);
        end
        wr_reg(3'h2, 8'hDB);
        repeat (12) @(posedge i_mclk);
        wr_reg(3'h3, 8'h45);
        chk(16'(sel), 16'h0023);
        wait_done;
        repeat (4) @(posedge i_mclk);
        chk(16'(sel), 16'h0025);
        rd_reg(3'h0, d);
        chk(d, 16'h00A3);
        rd_reg(3'h1, d);
        rd_reg(3'h0, d);
        conv(3'h3);
        chk(16'(irq), 16'h0001);
        rd_reg(3'h0, d);
        chk(d, 16'h00A3);
        rd_reg(3'h1, d);
        chk(d, 16'h0002);
        conv(3'h3);
        rd_reg(3'h0, d);
        chk(d, 16'h00A5);
        rd_reg(3'h1, d);
        wr_reg(3'h4, 8'h40);
        wr_reg(3'h2, 8'hBB);
        n0 = sh_n;
        @(posedge i_mclk);
        trig <= 8'h04;
        repeat (40) @(posedge i_mclk);
        chk(in_rng(sh_cyc - tr_cyc, 18, 23), 16'h0001);
        rd_reg(3'h2, d);
        chk(d, 16'h00EB);
        @(posedge i_mclk);
        trig <= 8'h00;
        @(posedge i_mclk);
        trig <= 8'h04;
        wait_done;
        repeat (300) @(posedge i_mclk);
        chk(16'(sh_n - n0), 16'h0001);
        trig <= 8'h00;
        wr_reg(3'h2, 8'hFB);
        wait_done;
        chk(16'(sh_n - n0), 16'h0002);
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h2, 8'hFB);
        wait_samples(3);
        chk(16'(sh_gap), 16'd104);
        rd_reg(3'h2, d);
        chk(d, 16'h00FB);
        wr_reg(3'h3, 8'h48);
        wait_samples(3);
        chk(16'(sh_gap), 16'd112);
        wr_reg(3'h2, 8'h00);
        chk(16'(aen), 16'h0000);
        rd_reg(3'h2, d);
        chk(d, 16'h0010);
        end_of_test;
    end
endmodule // tb_top
